// File: verilog/sasc_consts.vh
// Constants for the SAR converter sequencing control block.
// Assumes inclusion by the single design file under verilog/ and by the bench.
`ifndef SASC_CONSTS_VH
`define SASC_CONSTS_VH
`define SASC_ADR_PAIR_CFG 8'hba
`define SASC_ADR_CHAN_SEL 8'hbb
`define SASC_ADR_CONFIG   8'hbc
`define SASC_ADR_CONTROL  8'he8
`define SASC_ADR_RES_HI   8'hbf
`define SASC_ADR_RES_LO   8'hbe
`define SASC_RST_PAIR_CFG 8'h00
`define SASC_RST_CHAN_SEL 8'h00
`define SASC_RST_CONFIG   8'hf8
`define SASC_RST_CONTROL  8'h00
`define SASC_CTL_POWER    7
`define SASC_CTL_LPTRACK  6
`define SASC_CTL_DONE     5
`define SASC_CTL_BUSY     4
`define SASC_CTL_MODE_HI  3
`define SASC_CTL_MODE_LO  2
`define SASC_CTL_LJUST    0
`define SASC_MODE_SW      2'h0
`define SASC_MODE_TMR3    2'h1
`define SASC_MODE_EXT     2'h2
`define SASC_MODE_TMR2    2'h3
`define SASC_TRACK_CLKS   4'h3
`define SASC_CONV_CLKS    5'h10
`define SASC_TEMP_CHAN    4'h8
`define SASC_CFG_DIV_HI   7
`define SASC_CFG_DIV_LO   3
`define SASC_CFG_GAIN_HI  2
`define SASC_CFG_GAIN_LO  0
`define SASC_NIBBLE_HI    3
`endif

// File: verilog/sasc_top.v
// SAR converter sequencing control: registers, triggers, conversion timing.
// Assumes an 8-bit register port from the host core and a digitised result
// from the analog macro, valid when the conversion ends.
`timescale 1ns/10ps
`include "sasc_consts.vh"

module sasc_top #(
  parameter RES_W = 12
) (
  input  wire             clk_sys_in,
  input  wire             rst_b_in,
  input  wire [7:0]       reg_addr_in,
  input  wire             reg_wr_in,
  input  wire             reg_rd_in,
  input  wire [7:0]       reg_wdata_in,
  input  wire             irq_enable_in,
  input  wire             timer3_ovf_in,
  input  wire             timer2_ovf_in,
  input  wire             external_convert_start_in,
  input  wire             chip_sleep_in,
  input  wire [RES_W-1:0] sar_result_in,
  output reg  [7:0]       reg_rdata_out,
  output reg              converter_power_on_out,
  output reg              track_enable_out,
  output reg              sample_hold_out,
  output reg  [3:0]       mux_pos_out,
  output reg  [3:0]       mux_neg_out,
  output reg              mux_diff_out,
  output reg  [2:0]       gain_select_out,
  output reg              sar_clk_en_out,
  output reg              conv_done_irq_out
);

  // Sequencer states.
  localparam ST_IDLE  = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_CONV  = 2'h2;

  reg [7:0]       input_pair_config_reg_r;
  reg [7:0]       channel_select_reg_r;
  reg [7:0]       converter_config_reg_r;
  reg [7:0]       converter_control_reg_r;
  reg [7:0]       result_high_byte_r;
  reg [7:0]       result_low_byte_r;
  reg [1:0]       state_r;
  reg [4:0]       div_cnt_r;
  reg [4:0]       step_cnt_r;
  reg             ext_meta_r;
  reg             ext_sync_r;
  reg             ext_prev_r;
  reg             slp_meta_r;
  reg             slp_sync_r;
  reg             busy_wr_r;
  reg             conv_diff_r;

  wire       power_on  = converter_control_reg_r[`SASC_CTL_POWER];
  wire       lp_track  = converter_control_reg_r[`SASC_CTL_LPTRACK];
  wire [1:0] start_mode = {converter_control_reg_r[`SASC_CTL_MODE_HI],
                           converter_control_reg_r[`SASC_CTL_MODE_LO]};
  wire [3:0] chan      = channel_select_reg_r[`SASC_NIBBLE_HI:0];
  wire       ext_rise  = ext_sync_r & ~ext_prev_r;
  wire       wr_ctl    = reg_wr_in && (reg_addr_in == `SASC_ADR_CONTROL);
  wire       sar_tick  = (div_cnt_r == 5'h00);
  wire [4:0] div_fld   = converter_config_reg_r[`SASC_CFG_DIV_HI:`SASC_CFG_DIV_LO];
  wire [2:0] gain_fld  = converter_config_reg_r[`SASC_CFG_GAIN_HI:`SASC_CFG_GAIN_LO];
  wire [3:0] wr_nib    = reg_wdata_in[`SASC_NIBBLE_HI:0];

  // Pair configuration bit that governs a given external channel.
  function pair_bit;
    input [3:0] ch;
    input [7:0] cfg;
    begin
      pair_bit = cfg[ch[2:1]];
    end
  endfunction

  // Trigger selection by start mode; external edge only counts in idle.
  reg start_evt;
  always @* begin
    case (start_mode)
      `SASC_MODE_SW:   start_evt = busy_wr_r;
      `SASC_MODE_TMR3: start_evt = timer3_ovf_in;
      `SASC_MODE_EXT:  start_evt = ext_rise;
      default:         start_evt = timer2_ovf_in;
    endcase
  end

  // Multiplexer routing; odd channels of a differential pair follow the even one.
  reg [3:0] pos_nxt;
  reg [3:0] neg_nxt;
  reg       diff_nxt;
  always @* begin
    pos_nxt  = chan;
    neg_nxt  = 4'h0;
    diff_nxt = 1'b0;
    if (chan[3]) begin
      pos_nxt = `SASC_TEMP_CHAN;
    end else if (pair_bit(chan, input_pair_config_reg_r)) begin
      pos_nxt  = {1'b0, chan[2:1], 1'b0};
      neg_nxt  = {1'b0, chan[2:1], 1'b1};
      diff_nxt = 1'b1;
    end
  end

  // Result with sign handling, then justified into the byte pair.
  wire [RES_W-1:0] res_fmt = conv_diff_r ? (sar_result_in ^ {1'b1, {(RES_W-1){1'b0}}})
                                         : sar_result_in;
  wire [15:0] res_right = conv_diff_r ? {{(16-RES_W){res_fmt[RES_W-1]}}, res_fmt}
                                      : {{(16-RES_W){1'b0}}, res_fmt};
  wire [15:0] res_left  = {res_fmt, {(16-RES_W){1'b0}}};
  wire [15:0] res_word  = converter_control_reg_r[`SASC_CTL_LJUST] ? res_left
                                                                   : res_right;

  // Convert-start pin synchroniser; it resets to the pin's idle high level so
  // that no false rising edge follows reset.
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_meta_r <= 1'b1;
      ext_sync_r <= 1'b1;
      ext_prev_r <= 1'b1;
    end else begin
      ext_meta_r <= external_convert_start_in;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  // Sleep request synchroniser.
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      slp_meta_r <= 1'b0;
      slp_sync_r <= 1'b0;
    end else begin
      slp_meta_r <= chip_sleep_in;
      slp_sync_r <= slp_meta_r;
    end
  end

  // Divider producing one enable pulse per conversion clock.
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt_r      <= 5'h00;
      sar_clk_en_out <= 1'b0;
    end else if (!power_on) begin
      div_cnt_r      <= 5'h00;
      sar_clk_en_out <= 1'b0;
    end else begin
      if (sar_tick)
        div_cnt_r <= div_fld;
      else
        div_cnt_r <= div_cnt_r - 5'h01;
      sar_clk_en_out <= sar_tick;
    end
  end

  // Registers, sequencer and status.
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input_pair_config_reg_r <= `SASC_RST_PAIR_CFG;
      channel_select_reg_r    <= `SASC_RST_CHAN_SEL;
      converter_config_reg_r  <= `SASC_RST_CONFIG;
      converter_control_reg_r <= `SASC_RST_CONTROL;
      result_high_byte_r      <= 8'h00;
      result_low_byte_r       <= 8'h00;
      state_r                 <= ST_IDLE;
      step_cnt_r              <= 5'h00;
      busy_wr_r               <= 1'b0;
      conv_diff_r             <= 1'b0;
      conv_done_irq_out       <= 1'b0;
    end else begin
      // A busy write starts the sequencer one cycle later, once the write has landed.
      busy_wr_r <= wr_ctl && reg_wdata_in[`SASC_CTL_BUSY];
      // Upper nibbles of the pair and channel registers are not kept and read as zero.
      if (reg_wr_in) begin
        if (reg_addr_in == `SASC_ADR_PAIR_CFG)
          input_pair_config_reg_r <= {4'h0, wr_nib};
        else if (reg_addr_in == `SASC_ADR_CHAN_SEL)
          channel_select_reg_r <= {4'h0, wr_nib};
        else if (reg_addr_in == `SASC_ADR_CONFIG)
          converter_config_reg_r <= reg_wdata_in;
        else if (wr_ctl)
          converter_control_reg_r <= {reg_wdata_in[7:5],
                                      converter_control_reg_r[`SASC_CTL_BUSY],
                                      reg_wdata_in[3:0]};
      end
      conv_done_irq_out <= 1'b0;
      if (!power_on) begin
        state_r <= ST_IDLE;
        converter_control_reg_r[`SASC_CTL_BUSY] <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (start_evt) begin
              converter_control_reg_r[`SASC_CTL_BUSY] <= 1'b1;
              conv_diff_r <= diff_nxt;
              if (lp_track && start_mode != `SASC_MODE_EXT) begin
                state_r    <= ST_TRACK;
                step_cnt_r <= {1'b0, `SASC_TRACK_CLKS};
              end else begin
                state_r    <= ST_CONV;
                step_cnt_r <= `SASC_CONV_CLKS;
              end
            end
          end
          ST_TRACK: begin
            if (sar_tick) begin
              if (step_cnt_r == 5'h01) begin
                state_r    <= ST_CONV;
                step_cnt_r <= `SASC_CONV_CLKS;
              end else begin
                step_cnt_r <= step_cnt_r - 5'h01;
              end
            end
          end
          ST_CONV: begin
            if (sar_tick) begin
              if (step_cnt_r == 5'h01) begin
                state_r <= ST_IDLE;
                converter_control_reg_r[`SASC_CTL_BUSY] <= 1'b0;
                // Placed after the register write so a same-cycle clear of done loses.
                converter_control_reg_r[`SASC_CTL_DONE] <= 1'b1;
                conv_done_irq_out  <= irq_enable_in;
                result_high_byte_r <= res_word[15:8];
                result_low_byte_r  <= res_word[7:0];
              end else begin
                step_cnt_r <= step_cnt_r - 5'h01;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Register read port; the data stands until the next read.
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `SASC_ADR_PAIR_CFG)
        reg_rdata_out <= input_pair_config_reg_r;
      else if (reg_addr_in == `SASC_ADR_CHAN_SEL)
        reg_rdata_out <= channel_select_reg_r;
      else if (reg_addr_in == `SASC_ADR_CONFIG)
        reg_rdata_out <= converter_config_reg_r;
      else if (reg_addr_in == `SASC_ADR_CONTROL)
        reg_rdata_out <= converter_control_reg_r;
      else if (reg_addr_in == `SASC_ADR_RES_HI)
        reg_rdata_out <= result_high_byte_r;
      else if (reg_addr_in == `SASC_ADR_RES_LO)
        reg_rdata_out <= result_low_byte_r;
      else
        reg_rdata_out <= 8'h00;
    end
  end

  // Analog control outputs, registered.
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      converter_power_on_out <= 1'b0;
      track_enable_out       <= 1'b0;
      sample_hold_out        <= 1'b0;
      mux_pos_out            <= 4'h0;
      mux_neg_out            <= 4'h0;
      mux_diff_out           <= 1'b0;
      gain_select_out        <= 3'h0;
    end else begin
      converter_power_on_out <= power_on;
      // Hold follows the registered state, so it falls one cycle after done is raised.
      sample_hold_out        <= power_on && (state_r == ST_CONV);
      if (!power_on || slp_sync_r)
        track_enable_out <= 1'b0;
      else if (lp_track && start_mode == `SASC_MODE_EXT)
        track_enable_out <= (state_r == ST_IDLE) && !ext_sync_r;
      else if (lp_track)
        track_enable_out <= (state_r == ST_TRACK);
      else
        track_enable_out <= (state_r != ST_CONV);
      mux_pos_out     <= pos_nxt;
      mux_neg_out     <= neg_nxt;
      mux_diff_out    <= diff_nxt;
      gain_select_out <= gain_fld;
    end
  end

endmodule

// File: dv/sasc_props.sv
// Port checker for the SAR sequencing control.
// Assumes it is bound into sasc_top and sees only its ports.
`timescale 1ns/10ps
module sasc_props (
  input wire       clk_sys_in,
  input wire       rst_b_in,
  input wire [7:0] reg_addr_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_wdata_in,
  input wire       chip_sleep_in,
  input wire       irq_enable_in,
  input wire [7:0] reg_rdata_out,
  input wire       converter_power_on_out,
  input wire       track_enable_out,
  input wire       sample_hold_out,
  input wire [3:0] mux_pos_out,
  input wire [3:0] mux_neg_out,
  input wire       mux_diff_out,
  input wire [2:0] gain_select_out,
  input wire       conv_done_irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  AST_PWR: assert property (
    !converter_power_on_out [*2] |-> !sample_hold_out && !track_enable_out)
    else $error("active while powered off");
  AST_GAIN: assert property (reg_wr_in && reg_addr_in == 8'hbc |->
    ##[1:2] gain_select_out == $past(reg_wdata_in[2:0])) else $error("gain not applied");
  AST_DIFF: assert property (mux_diff_out |-> !mux_pos_out[0] && !mux_pos_out[3] &&
    mux_neg_out == mux_pos_out + 4'h1) else $error("bad differential pair");
  AST_HOLD: assert property ($rose(sample_hold_out) |-> sample_hold_out [*8])
    else $error("conversion too short");
  AST_TRK: assert property (sample_hold_out |-> !track_enable_out)
    else $error("tracking during conversion");
  AST_IRQ: assert property (conv_done_irq_out |=> !sample_hold_out && !conv_done_irq_out)
    else $error("done pulse malformed");
  AST_IRQ_OFF: assert property (!irq_enable_in |=> !conv_done_irq_out)
    else $error("interrupt while disabled");
  AST_SLEEP: assert property (chip_sleep_in [*5] |-> !track_enable_out)
    else $error("tracking while asleep");
  AST_PAIR: assert property (reg_rd_in && reg_addr_in == 8'hba |=>
    reg_rdata_out[7:4] == 4'h0) else $error("unused pair bits set");
endmodule
bind sasc_top sasc_props sasc_props_inst (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wr_in,
  .reg_rd_in, .reg_wdata_in, .chip_sleep_in, .irq_enable_in, .reg_rdata_out,
  .converter_power_on_out,
  .track_enable_out, .sample_hold_out, .mux_pos_out, .mux_neg_out, .mux_diff_out,
  .gain_select_out, .conv_done_irq_out);

// File: dv/sasc_partner.sv
// Timer overflows, convert-start pin and analog result for the block.
// Assumes the bench raises fire_in at a falling edge of clk_in.
`timescale 1ns/10ps
module sasc_partner (
  input  wire        clk_in,
  input  wire [1:0]  kind_in,
  input  wire        fire_in,
  input  wire        hold_in,
  input  wire [11:0] code_in,
  output reg         t3_out,
  output reg         t2_out,
  output reg         pin_out,
  output reg  [11:0] res_out
);
  initial {t3_out, t2_out, pin_out, res_out} = {3'h1, 12'h000};
  // The result is only valid while held; otherwise it toggles to expose a late sample.
  always @(posedge clk_in) begin
    t3_out  <= fire_in && kind_in == 2'h1;
    t2_out  <= fire_in && kind_in == 2'h3;
    pin_out <= !(fire_in && kind_in == 2'h2);
    res_out <= hold_in ? code_in : ~res_out;
  end
endmodule

// File: dv/tb.sv
// Self-checking bench for the SAR sequencing control block.
// Assumes sasc_top under verilog/ and the trigger model sasc_partner.
`timescale 1ns/10ps
`include "sasc_consts.vh"
module tb;
  reg         clk_sys_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  reg  [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, v = 8'h00;
  reg         chip_sleep_in = 1'b0, fire = 1'b0, irq_enable_in = 1'b1;
  reg  [1:0]  kind = 2'h0;
  wire        t3, t2, pin, pwr, trk, hold, diff, sclk, irq;
  wire [11:0] res;
  wire [7:0]  rdata;
  wire [3:0]  pos, neg;
  wire [2:0]  gain;
  integer     failures = 0, n_tests = 0, irqs = 0, cnt = 0, gap = 0, i, j;
  sasc_top sasc_top_inst (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .irq_enable_in, .timer3_ovf_in(t3), .timer2_ovf_in(t2),
    .external_convert_start_in(pin), .chip_sleep_in, .sar_result_in(res),
    .reg_rdata_out(rdata), .converter_power_on_out(pwr), .track_enable_out(trk),
    .sample_hold_out(hold), .mux_pos_out(pos), .mux_neg_out(neg), .mux_diff_out(diff),
    .gain_select_out(gain), .sar_clk_en_out(sclk), .conv_done_irq_out(irq));
  sasc_partner sasc_partner_inst (.clk_in(clk_sys_in), .kind_in(kind), .fire_in(fire),
    .hold_in(hold), .code_in(12'ha5c), .t3_out(t3), .t2_out(t2), .pin_out(pin), .res_out(res));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (irq === 1'b1) irqs = irqs + 1;
    if (sclk === 1'b1) {gap, cnt} = {cnt, 32'd1};
    else cnt = cnt + 1;
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys_in);
      {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
      @(negedge clk_sys_in);
      reg_wr_in = 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge clk_sys_in);
      {reg_addr_in, reg_rd_in} = {a, 1'b1};
      @(negedge clk_sys_in);
      reg_rd_in = 1'b0;
      v = rdata;
    end
  endtask
  task poll(input [7:0] msk);
    begin
      v = 8'h00;
      for (i = 0; i < 200 && (v & msk) !== msk; i = i + 1) rd(`SASC_ADR_CONTROL);
      chk(v & msk, msk);
      if ((v & msk) !== msk) test_done;
    end
  endtask
  task conv(input [1:0] m, input [7:0] c, input [7:0] hi, input [7:0] lo);
    begin
      kind = m;
      wr(`SASC_ADR_CONTROL, c | {4'h0, m, 2'h0});
      if (m == `SASC_MODE_SW) wr(`SASC_ADR_CONTROL, c | 8'h10);
      else begin
        fire = 1'b1;
        repeat (m == `SASC_MODE_EXT ? 4 : 1) @(negedge clk_sys_in);
        fire = 1'b0;
      end
      poll(8'h10);
      poll(8'h20);
      chk(v & 8'h10, 8'h00);
      rd(`SASC_ADR_RES_HI);
      chk(v, hi);
      rd(`SASC_ADR_RES_LO);
      chk(v, lo);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    rd(`SASC_ADR_PAIR_CFG);
    chk(v, `SASC_RST_PAIR_CFG);
    rd(`SASC_ADR_CONFIG);
    chk(v, `SASC_RST_CONFIG);
    chk({4'h0, gain, diff}, 8'h00);
    rd(8'h00);
    chk(v, 8'h00);
    for (j = 0; j < 8; j = j + 1) begin
      wr(`SASC_ADR_CONFIG, {5'h01, j[2:0]});
      rd(`SASC_ADR_CONFIG);
      chk({v[7:3], gain}, {5'h01, j[2:0]});
    end
    wr(`SASC_ADR_CONFIG, 8'h08);
    wr(`SASC_ADR_PAIR_CFG, 8'hff);
    wr(`SASC_ADR_CONTROL, 8'h80);
    rd(`SASC_ADR_PAIR_CFG);
    chk({pos, neg}, 8'h01);
    chk({v[7:1], diff}, 8'h0f);
    wr(`SASC_ADR_CHAN_SEL, 8'h08);
    rd(`SASC_ADR_CHAN_SEL);
    chk({pos, 2'h0, trk, diff}, 8'h82);
    chip_sleep_in = 1'b1;
    repeat (3) rd(`SASC_ADR_CONTROL);
    chk({6'h00, pwr, trk}, 8'h02);
    chip_sleep_in = 1'b0;
    wr(`SASC_ADR_PAIR_CFG, 8'h00);
    wr(`SASC_ADR_CHAN_SEL, 8'h03);
    for (j = 0; j < 4; j = j + 1) conv(j[1:0], 8'h80, 8'h0a, 8'h5c);
    chk(gap[7:0], 8'h02);
    wr(`SASC_ADR_PAIR_CFG, 8'h02);
    wr(`SASC_ADR_CHAN_SEL, 8'h02);
    conv(`SASC_MODE_SW, 8'h81, 8'h25, 8'hc0);
    conv(`SASC_MODE_SW, 8'hc0, 8'h02, 8'h5c);
    conv(`SASC_MODE_EXT, 8'hc0, 8'h02, 8'h5c);
    irq_enable_in = 1'b0;
    conv(`SASC_MODE_SW, 8'h80, 8'h02, 8'h5c);
    irq_enable_in = 1'b1;
    chk(irqs[7:0], 8'h07);
    wr(`SASC_ADR_CONTROL, 8'h00);
    rd(`SASC_ADR_CONTROL);
    chk({6'h00, pwr, trk}, 8'h00);
    test_done;
  end
endmodule
